// *** pkg/ndea_pkg.sv ***
// Shared constants and types of the nonvolatile byte store access block.
package ndea_pkg;

	// ******************************************************************
	// Widths
	// ******************************************************************
	localparam int NDEA_AW = 8;
	localparam int NDEA_DW = 8;
	localparam int NDEA_RAW = 3;
	localparam int NDEA_CNT_W = 16;

	// ******************************************************************
	// Register offsets
	// ******************************************************************
	localparam logic [NDEA_RAW-1:0] NDEA_REG_CTRL = 3'h0;
	localparam logic [NDEA_RAW-1:0] NDEA_REG_UNLOCK = 3'h1;
	localparam logic [NDEA_RAW-1:0] NDEA_REG_VALUE = 3'h2;
	localparam logic [NDEA_RAW-1:0] NDEA_REG_POINTER = 3'h3;
	localparam logic [NDEA_RAW-1:0] NDEA_REG_FLAGS = 3'h4;
	localparam logic [NDEA_RAW-1:0] NDEA_REG_MASK = 3'h5;

	// ******************************************************************
	// Field positions
	// ******************************************************************
	localparam int NDEA_CB_FETCH = 0;
	localparam int NDEA_CB_WRITE = 1;
	localparam int NDEA_CB_PERMIT = 2;
	localparam int NDEA_CB_FAULT = 3;
	localparam int NDEA_CB_CONFIG = 6;
	localparam int NDEA_CB_FLASH = 7;
	localparam int NDEA_FB_DONE = 0;
	localparam int NDEA_FB_FAULT = 1;
	localparam int NDEA_FLAG_W = 2;

	// ******************************************************************
	// Values
	// ******************************************************************
	localparam logic [NDEA_DW-1:0] NDEA_ZERO = 8'h00;
	localparam logic [NDEA_DW-1:0] NDEA_ERASED = 8'hFF;
	localparam logic [NDEA_DW-1:0] NDEA_KEY_FIRST = 8'h55;
	localparam logic [NDEA_DW-1:0] NDEA_KEY_SECOND = 8'hAA;
	localparam logic [1:0] NDEA_UNLOCK_NONE = 2'h0;
	localparam logic [1:0] NDEA_UNLOCK_HALF = 2'h1;
	localparam logic [1:0] NDEA_UNLOCK_ARMED = 2'h2;
	localparam logic [NDEA_FLAG_W-1:0] NDEA_FLAGS_RST = 2'h0;

	// ******************************************************************
	// Timing
	// ******************************************************************
	localparam int NDEA_CLK_MHZ = 100;
	localparam int NDEA_ERASE_NS = 2000;
	localparam int NDEA_PROG_NS = 2000;
	localparam int NDEA_ERASE_CYC = (NDEA_ERASE_NS * NDEA_CLK_MHZ + 999) / 1000;
	localparam int NDEA_PROG_CYC = (NDEA_PROG_NS * NDEA_CLK_MHZ + 999) / 1000;

	// ******************************************************************
	// Types
	// ******************************************************************
	typedef enum logic [3:0] {
		NDEA_ST_IDLE = 4'b0001,
		NDEA_ST_ERASE = 4'b0010,
		NDEA_ST_PROG = 4'b0100,
		NDEA_ST_DONE = 4'b1000
	} ndea_cell_state_t;

	typedef enum logic [1:0] {
		NDEA_TGT_DATA = 2'h0,
		NDEA_TGT_PROGRAM = 2'h1,
		NDEA_TGT_CONFIG = 2'h2
	} ndea_target_t;

endpackage

// *** logic/ndea_cell_array.sv ***
// Byte array of the nonvolatile store with one write and one read port.
`timescale 1ns/1ns

module ndea_cell_array #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock.
	input wire logic clk_in,
	// Write port.
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [DW-1:0] wdata_in,
	// Read port.
	input wire logic [AW-1:0] raddr_in,
	output logic [DW-1:0] rdata_out
);

	// The cells are nonvolatile, so they take no reset.
	logic [DW-1:0] cells [0:(1<<AW)-1];

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			cells[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		rdata_out <= cells[raddr_in];
	end

endmodule // ndea_cell_array

// *** logic/ndea_top.sv ***
// Register front end, unlock, self-timed write and fetch of the byte store.
`timescale 1ns/1ns

// How it works
// RL1: An 8-bit pointer selects one of 256 store bytes, 00h to FFh.
// RL2: Value register holds the byte to program, and the byte fetched.
// RL3: A write erases the byte first, then programs it, by itself.
// RL4: An internal counter times each programming cycle, not software.
// RL5: Flash select clear targets the data store, set targets program memory.
// RL6: Config select set targets configuration space, overriding flash select.
// RL7: Writes start only while program permit is set; it resets to zero.
// RL8: Fault flag sets when a write starts, clears when it ends normally.
// RL9: Fault flag stays set after reset mid-write or an improper attempt.
// RL10: Software can set the write start bit only; hardware clears it.
// RL11: Done flag sets when a write completes; software clears it.
// RL12: Fetch start reads the addressed byte; hardware then clears the bit.
// RL13: Fetch start is ignored when the same control write sets flash select or config select.
// RL14: Unlock port stores nothing and always reads as zero.
// RL15: Software writes the unlock keys before starting a write.
// RL16: During a write, new starts and pointer or value writes are ignored.
module ndea_top
	import ndea_pkg::*;
#(
	parameter int ERASE_CYCLES = NDEA_ERASE_CYC,
	parameter int PROG_CYCLES = NDEA_PROG_CYC
) (
	// Clock and reset.
	input wire logic CORE_CLK_IN,
	input wire logic RST_B_IN,
	// Register port.
	input wire logic [NDEA_RAW-1:0] REG_ADDR_IN,
	input wire logic [NDEA_DW-1:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [NDEA_DW-1:0] REG_RDATA_OUT,
	// Status.
	output logic IRQ_OUT,
	output logic PROG_BUSY_OUT,
	output logic [1:0] TARGET_OUT
);

	// ******************************************************************
	// Decoding helpers
	// ******************************************************************
	function automatic ndea_target_t target_of(input logic flash,
		input logic cfg);
		ndea_target_t t;
		t = NDEA_TGT_DATA;
		if (cfg) begin
			t = NDEA_TGT_CONFIG;
		end else if (flash) begin
			t = NDEA_TGT_PROGRAM;
		end
		return t;
	endfunction

	// ******************************************************************
	// Declarations
	// ******************************************************************
	logic flash_select;
	logic config_space_select;
	logic program_permit;
	logic program_fault_flag;
	logic write_start_bit;
	logic fetch_start_bit;
	logic fetch_stage;
	logic [NDEA_AW-1:0] nv_byte_pointer;
	logic [NDEA_DW-1:0] nv_byte_value;
	logic [NDEA_FLAG_W-1:0] flag_status;
	logic [NDEA_FLAG_W-1:0] flag_mask;
	logic [NDEA_FLAG_W-1:0] flag_events;
	logic [1:0] unlock_stage;
	ndea_cell_state_t state;
	ndea_cell_state_t next_state;
	ndea_target_t cycle_target;
	logic [NDEA_CNT_W-1:0] cell_count;
	logic sel_ctrl;
	logic sel_unlock;
	logic sel_value;
	logic sel_pointer;
	logic sel_flags;
	logic sel_mask;
	logic busy;
	logic start_ask;
	logic start_ok;
	logic start_bad;
	logic fetch_ok;
	logic fetch_end;
	logic erase_end;
	logic prog_end;
	logic arr_we;
	logic [NDEA_DW-1:0] arr_wdata;
	logic [NDEA_DW-1:0] arr_rdata;
	logic [NDEA_DW-1:0] next_rdata;

	// ******************************************************************
	// Address decode
	// ******************************************************************
	always_comb begin
		sel_ctrl = 1'b0;
		sel_unlock = 1'b0;
		sel_value = 1'b0;
		sel_pointer = 1'b0;
		sel_flags = 1'b0;
		sel_mask = 1'b0;
		if (REG_ADDR_IN == NDEA_REG_CTRL) begin
			sel_ctrl = 1'b1;
		end else if (REG_ADDR_IN == NDEA_REG_UNLOCK) begin
			sel_unlock = 1'b1;
		end else if (REG_ADDR_IN == NDEA_REG_VALUE) begin
			sel_value = 1'b1;
		end else if (REG_ADDR_IN == NDEA_REG_POINTER) begin
			sel_pointer = 1'b1;
		end else if (REG_ADDR_IN == NDEA_REG_FLAGS) begin
			sel_flags = 1'b1;
		end else if (REG_ADDR_IN == NDEA_REG_MASK) begin
			sel_mask = 1'b1;
		end
	end

	// ******************************************************************
	// Request qualification
	// ******************************************************************
	assign busy = (state != NDEA_ST_IDLE);
	assign start_ask = REG_WR_IN && sel_ctrl && REG_WDATA_IN[NDEA_CB_WRITE];
	assign start_ok = start_ask && !busy && program_permit && // RL7
		(unlock_stage == NDEA_UNLOCK_ARMED); // RL15
	assign start_bad = start_ask && !busy && !start_ok; // RL9
	// A fetch asked in the same write as a good start would reload the
	// value register under the running cycle, so the start takes it.
	assign fetch_ok = REG_WR_IN && sel_ctrl && !start_ok &&
		REG_WDATA_IN[NDEA_CB_FETCH] && !busy && !fetch_start_bit &&
		(target_of(REG_WDATA_IN[NDEA_CB_FLASH],
		REG_WDATA_IN[NDEA_CB_CONFIG]) == NDEA_TGT_DATA); // RL13
	assign fetch_end = fetch_start_bit && fetch_stage;
	assign erase_end = (state == NDEA_ST_ERASE) &&
		(cell_count == NDEA_CNT_W'(ERASE_CYCLES - 1));
	assign prog_end = (state == NDEA_ST_PROG) &&
		(cell_count == NDEA_CNT_W'(PROG_CYCLES - 1));

	// ******************************************************************
	// Unlock sequence
	// ******************************************************************
	// The port itself has no storage; only the progress through the keys
	// is remembered, and any other write breaks the sequence.
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			unlock_stage <= NDEA_UNLOCK_NONE;
		end else if (REG_WR_IN && sel_unlock) begin
			if (REG_WDATA_IN == NDEA_KEY_FIRST) begin
				unlock_stage <= NDEA_UNLOCK_HALF;
			end else if (unlock_stage == NDEA_UNLOCK_HALF &&
				REG_WDATA_IN == NDEA_KEY_SECOND) begin
				unlock_stage <= NDEA_UNLOCK_ARMED; // RL15
			end else begin
				unlock_stage <= NDEA_UNLOCK_NONE;
			end
		end else if (REG_WR_IN) begin
			unlock_stage <= NDEA_UNLOCK_NONE;
		end
	end

	// ******************************************************************
	// Control register
	// ******************************************************************
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			flash_select <= 1'b0;
			config_space_select <= 1'b0;
			program_permit <= 1'b0; // RL7
		end else if (REG_WR_IN && sel_ctrl) begin
			program_permit <= REG_WDATA_IN[NDEA_CB_PERMIT];
			if (!busy) begin
				flash_select <= REG_WDATA_IN[NDEA_CB_FLASH]; // RL5
				config_space_select <= REG_WDATA_IN[NDEA_CB_CONFIG]; // RL6
			end
		end
	end

	// The fault flag deliberately survives reset when a cycle was cut off,
	// so software can see the loss after the restart.
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			if (write_start_bit || program_fault_flag) begin
				program_fault_flag <= 1'b1; // RL9
			end else begin
				program_fault_flag <= 1'b0;
			end
		end else if (start_ok || start_bad) begin
			program_fault_flag <= 1'b1; // RL8
		end else if (prog_end) begin
			program_fault_flag <= 1'b0; // RL8
		end else if (REG_WR_IN && sel_ctrl && !busy) begin
			program_fault_flag <= REG_WDATA_IN[NDEA_CB_FAULT];
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			write_start_bit <= 1'b0;
		end else if (start_ok) begin
			write_start_bit <= 1'b1; // RL10
		end else if (state == NDEA_ST_DONE) begin
			write_start_bit <= 1'b0; // RL10
		end
	end

	// ******************************************************************
	// Fetch
	// ******************************************************************
	// The array answers one edge after the pointer is presented, so the
	// fetch takes two cycles before the start bit drops.
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			fetch_start_bit <= 1'b0;
			fetch_stage <= 1'b0;
		end else if (fetch_ok) begin
			fetch_start_bit <= 1'b1; // RL12
			fetch_stage <= 1'b0;
		end else if (fetch_end) begin
			fetch_start_bit <= 1'b0; // RL12
			fetch_stage <= 1'b0;
		end else if (fetch_start_bit) begin
			fetch_stage <= 1'b1;
		end
	end

	// ******************************************************************
	// Pointer and value
	// ******************************************************************
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			nv_byte_pointer <= NDEA_ZERO;
		end else if (REG_WR_IN && sel_pointer && !busy &&
			!fetch_start_bit) begin
			nv_byte_pointer <= REG_WDATA_IN; // RL1 RL16
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			nv_byte_value <= NDEA_ZERO;
		end else if (fetch_end) begin
			nv_byte_value <= arr_rdata; // RL2
		end else if (REG_WR_IN && sel_value && !busy &&
			!fetch_start_bit) begin
			nv_byte_value <= REG_WDATA_IN; // RL2 RL16
		end
	end

	// ******************************************************************
	// Self-timed write cycle
	// ******************************************************************
	always_comb begin
		next_state = state;
		case (state)
		NDEA_ST_IDLE: begin
			if (start_ok) begin
				next_state = NDEA_ST_ERASE; // RL3
			end
		end
		NDEA_ST_ERASE: begin
			if (erase_end) begin
				next_state = NDEA_ST_PROG; // RL3
			end
		end
		NDEA_ST_PROG: begin
			if (prog_end) begin
				next_state = NDEA_ST_DONE;
			end
		end
		NDEA_ST_DONE: begin
			next_state = NDEA_ST_IDLE;
		end
		default: begin
			next_state = NDEA_ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			state <= NDEA_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			cell_count <= '0;
		end else if (erase_end || prog_end || !busy) begin
			cell_count <= '0;
		end else begin
			cell_count <= cell_count + 1'b1; // RL4
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			cycle_target <= NDEA_TGT_DATA;
		end else if (start_ok) begin
			cycle_target <= target_of(flash_select, config_space_select);
		end
	end

	// Only the data store lives here; cycles aimed elsewhere run the timer
	// but leave the array untouched.
	always_comb begin
		arr_we = 1'b0;
		arr_wdata = NDEA_ERASED;
		if (cycle_target == NDEA_TGT_DATA) begin
			if (state == NDEA_ST_ERASE && cell_count == '0) begin
				arr_we = 1'b1; // RL3
			end else if (prog_end) begin
				arr_we = 1'b1; // RL3
				arr_wdata = nv_byte_value;
			end
		end
	end

	ndea_cell_array #(
		.AW(NDEA_AW),
		.DW(NDEA_DW)
	) u_cells (
		.clk_in(CORE_CLK_IN),
		.we_in(arr_we),
		.waddr_in(nv_byte_pointer),
		.wdata_in(arr_wdata),
		.raddr_in(nv_byte_pointer),
		.rdata_out(arr_rdata)
	);

	// ******************************************************************
	// Flags and interrupt
	// ******************************************************************
	always_comb begin
		flag_events = '0;
		flag_events[NDEA_FB_DONE] = (state == NDEA_ST_DONE); // RL11
		flag_events[NDEA_FB_FAULT] = start_bad;
	end

	// A flag raised in the same cycle as its clearing write stays raised.
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			flag_status <= NDEA_FLAGS_RST;
		end else if (REG_WR_IN && sel_flags) begin
			flag_status <= (flag_status &
				~REG_WDATA_IN[NDEA_FLAG_W-1:0]) | flag_events; // RL11
		end else begin
			flag_status <= flag_status | flag_events;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			flag_mask <= NDEA_FLAGS_RST;
		end else if (REG_WR_IN && sel_mask) begin
			flag_mask <= REG_WDATA_IN[NDEA_FLAG_W-1:0];
		end
	end

	assign IRQ_OUT = |(flag_status & flag_mask);

	// ******************************************************************
	// Read back
	// ******************************************************************
	always_comb begin
		next_rdata = NDEA_ZERO;
		if (sel_ctrl) begin
			next_rdata[NDEA_CB_FLASH] = flash_select;
			next_rdata[NDEA_CB_CONFIG] = config_space_select;
			next_rdata[NDEA_CB_FAULT] = program_fault_flag;
			next_rdata[NDEA_CB_PERMIT] = program_permit;
			next_rdata[NDEA_CB_WRITE] = write_start_bit;
			next_rdata[NDEA_CB_FETCH] = fetch_start_bit;
		end else if (sel_unlock) begin
			next_rdata = NDEA_ZERO; // RL14
		end else if (sel_value) begin
			next_rdata = nv_byte_value;
		end else if (sel_pointer) begin
			next_rdata = nv_byte_pointer;
		end else if (sel_flags) begin
			next_rdata[NDEA_FLAG_W-1:0] = flag_status;
		end else if (sel_mask) begin
			next_rdata[NDEA_FLAG_W-1:0] = flag_mask;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			REG_RDATA_OUT <= NDEA_ZERO;
		end else if (REG_RD_IN) begin
			REG_RDATA_OUT <= next_rdata;
		end else begin
			REG_RDATA_OUT <= NDEA_ZERO;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			PROG_BUSY_OUT <= 1'b0;
			TARGET_OUT <= NDEA_TGT_DATA;
		end else begin
			PROG_BUSY_OUT <= (next_state != NDEA_ST_IDLE);
			TARGET_OUT <= target_of(flash_select, config_space_select);
		end
	end

endmodule // ndea_top

// *** test/ndea_top_assertions.sv ***
// Concurrent checks on the ports of the byte store access block.
`timescale 1ns/1ns

module ndea_top_assertions
	import ndea_pkg::*;
#(
	parameter int ERASE_CYCLES = NDEA_ERASE_CYC,
	parameter int PROG_CYCLES = NDEA_PROG_CYC
) (
	// Clock and reset.
	input wire logic CORE_CLK_IN,
	input wire logic RST_B_IN,
	// Register port.
	input wire logic [NDEA_RAW-1:0] REG_ADDR_IN,
	input wire logic [NDEA_DW-1:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [NDEA_DW-1:0] REG_RDATA_OUT,
	// Status.
	input wire logic IRQ_OUT,
	input wire logic PROG_BUSY_OUT,
	input wire logic [1:0] TARGET_OUT
);
	// A repetition cannot take a parameter count, so busy time is counted.
	logic [NDEA_CNT_W-1:0] busy_cnt;
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN || !PROG_BUSY_OUT) begin
			busy_cnt <= '0;
		end else begin
			busy_cnt <= busy_cnt + 16'h0001;
		end
	end

	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_B_IN);

	unlock_reads_zero_a: assert property (
		$past(REG_RD_IN && REG_ADDR_IN == NDEA_REG_UNLOCK) |->
		REG_RDATA_OUT == NDEA_ZERO) else $error("unlock port read not zero");
	rdata_idle_a: assert property (
		!$past(REG_RD_IN) |-> REG_RDATA_OUT == NDEA_ZERO)
		else $error("read data outside its cycle");
	start_cause_a: assert property (
		$rose(PROG_BUSY_OUT) |-> $past(REG_WR_IN &&
		REG_ADDR_IN == NDEA_REG_CTRL && REG_WDATA_IN[NDEA_CB_WRITE] &&
		REG_WDATA_IN[NDEA_CB_PERMIT])) else $error("busy without start");
	busy_bound_a: assert property (
		PROG_BUSY_OUT |-> busy_cnt < ERASE_CYCLES + PROG_CYCLES + 2)
		else $error("write cycle overran its timer");
	busy_full_a: assert property (
		$fell(PROG_BUSY_OUT) |-> busy_cnt >= ERASE_CYCLES + PROG_CYCLES)
		else $error("write cycle ended early");
	target_select_a: assert property (
		(REG_WR_IN && REG_ADDR_IN == NDEA_REG_CTRL && !PROG_BUSY_OUT ##1
		!(REG_WR_IN && REG_ADDR_IN == NDEA_REG_CTRL)) |-> ##1
		TARGET_OUT == ($past(REG_WDATA_IN[NDEA_CB_CONFIG], 2) ? 2'h2 :
		{1'b0, $past(REG_WDATA_IN[NDEA_CB_FLASH], 2)}))
		else $error("target does not follow selects");
	target_hold_a: assert property (
		PROG_BUSY_OUT && $past(PROG_BUSY_OUT, 2) |-> $stable(TARGET_OUT))
		else $error("target moved during write");
	irq_cause_a: assert property (
		$rose(IRQ_OUT) |-> $fell(PROG_BUSY_OUT) || $past(REG_WR_IN &&
		(REG_ADDR_IN == NDEA_REG_CTRL || REG_ADDR_IN == NDEA_REG_MASK)))
		else $error("interrupt without cause");
endmodule // ndea_top_assertions

bind ndea_top ndea_top_assertions #(
	.ERASE_CYCLES(ERASE_CYCLES),
	.PROG_CYCLES(PROG_CYCLES)
) ndea_top_assertions_inst (
	.CORE_CLK_IN(CORE_CLK_IN),
	.RST_B_IN(RST_B_IN),
	.REG_ADDR_IN(REG_ADDR_IN),
	.REG_WDATA_IN(REG_WDATA_IN),
	.REG_WR_IN(REG_WR_IN),
	.REG_RD_IN(REG_RD_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT),
	.IRQ_OUT(IRQ_OUT),
	.PROG_BUSY_OUT(PROG_BUSY_OUT),
	.TARGET_OUT(TARGET_OUT)
);

// *** test/ndea_top_tb.sv ***
// Self-checking bench for the byte store access block.
`timescale 1ns/1ns

`define CHK(nm, ex, got) begin \
	checks_done++; \
	if ((got) !== (ex)) begin \
		failures++; \
		$display("BAD %s expected %h seen %h", nm, ex, got); \
	end \
end

module ndea_top_tb
	import ndea_pkg::*;
;
	// Short timer values keep the run brief yet leave room for busy checks.
	localparam int EC = 10;
	localparam int PC = 10;
	logic clk, rst_b, reg_wr, reg_rd, irq, busy;
	logic [NDEA_RAW-1:0] addr;
	logic [NDEA_DW-1:0] wdata, rdata, rv;
	logic [1:0] target;
	int failures, checks_done, cycles;
	logic [7:0] sel_v [4] = '{8'h81, 8'h40, 8'hC1, 8'h00};
	logic [1:0] sel_t [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
	logic [7:0] st_p [3] = '{8'hFF, 8'h00, 8'hFF};
	logic [7:0] st_v [3] = '{8'hA5, 8'h3C, 8'h5A};

	ndea_top #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) ndea_top_inst (
		.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
		.REG_RDATA_OUT(rdata), .IRQ_OUT(irq), .PROG_BUSY_OUT(busy),
		.TARGET_OUT(target));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// A hung wait would never end the run, so cycles are capped.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			$display("BAD timeout expected 0 seen 1");
			complete_run();
		end
	end

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = rdata;
	endtask

	task automatic chk_rd(input string nm, input logic [2:0] a,
		input logic [7:0] ex);
		rd_reg(a);
		`CHK(nm, ex, rv)
	endtask

	task automatic start(input logic [7:0] p, input logic [7:0] v);
		wr_reg(NDEA_REG_POINTER, p);
		wr_reg(NDEA_REG_VALUE, v);
		wr_reg(NDEA_REG_CTRL, 8'h04);
		wr_reg(NDEA_REG_UNLOCK, NDEA_KEY_FIRST);
		wr_reg(NDEA_REG_UNLOCK, NDEA_KEY_SECOND);
		wr_reg(NDEA_REG_CTRL, 8'h06);
		#1;
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic fetch(input logic [7:0] p);
		wr_reg(NDEA_REG_POINTER, p);
		wr_reg(NDEA_REG_VALUE, NDEA_ZERO);
		wr_reg(NDEA_REG_CTRL, 8'h01);
		repeat (3) @(posedge clk);
	endtask

	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		addr = '0;
		wdata = '0;
		failures = 0;
		checks_done = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			chk_rd("reset reg", 3'(i), NDEA_ZERO);
		end
		`CHK("reset irq", 1'b0, irq)
		$display("test reset done");
		wr_reg(NDEA_REG_UNLOCK, NDEA_KEY_FIRST);
		chk_rd("unlock", NDEA_REG_UNLOCK, NDEA_ZERO);
		wr_reg(NDEA_REG_CTRL, 8'h04);
		wr_reg(NDEA_REG_CTRL, 8'h06);
		#1 `CHK("busy keyless", 1'b0, busy)
		chk_rd("ctrl keyless", NDEA_REG_CTRL, 8'h0C);
		chk_rd("flags keyless", NDEA_REG_FLAGS, 8'h02);
		wr_reg(NDEA_REG_MASK, 8'h02);
		#1 `CHK("irq fault", 1'b1, irq)
		wr_reg(NDEA_REG_FLAGS, 8'h02);
		wr_reg(NDEA_REG_CTRL, 8'h00);
		wr_reg(NDEA_REG_UNLOCK, NDEA_KEY_FIRST);
		wr_reg(NDEA_REG_UNLOCK, NDEA_KEY_SECOND);
		wr_reg(NDEA_REG_CTRL, 8'h02);
		#1 `CHK("busy no permit", 1'b0, busy)
		chk_rd("ctrl no permit", NDEA_REG_CTRL, 8'h08);
		wr_reg(NDEA_REG_FLAGS, 8'h02);
		$display("test refused writes done");
		wr_reg(NDEA_REG_MASK, 8'h01);
		start(8'hFF, 8'hA5);
		`CHK("busy", 1'b1, busy)
		chk_rd("ctrl busy", NDEA_REG_CTRL, 8'h0E);
		wr_reg(NDEA_REG_CTRL, 8'h04);
		wr_reg(NDEA_REG_CTRL, 8'h06);
		wr_reg(NDEA_REG_POINTER, 8'h00);
		wr_reg(NDEA_REG_VALUE, 8'h11);
		chk_rd("ctrl clear try", NDEA_REG_CTRL, 8'h0E);
		chk_rd("value busy", NDEA_REG_VALUE, 8'hA5);
		chk_rd("pointer busy", NDEA_REG_POINTER, 8'hFF);
		wait_idle();
		chk_rd("ctrl done", NDEA_REG_CTRL, 8'h04);
		chk_rd("flags done", NDEA_REG_FLAGS, 8'h01);
		`CHK("irq done", 1'b1, irq)
		wr_reg(NDEA_REG_FLAGS, 8'h01);
		chk_rd("flags clear", NDEA_REG_FLAGS, 8'h00);
		`CHK("irq clear", 1'b0, irq)
		$display("test write cycle done");
		for (int i = 0; i < 3; i++) begin
			start(st_p[i], st_v[i]);
			wait_idle();
		end
		fetch(8'h00);
		chk_rd("fetch low", NDEA_REG_VALUE, 8'h3C);
		fetch(8'hFF);
		chk_rd("fetch high", NDEA_REG_VALUE, 8'h5A);
		chk_rd("ctrl fetch", NDEA_REG_CTRL, 8'h00);
		$display("test store and fetch done");
		wr_reg(NDEA_REG_VALUE, NDEA_ZERO);
		for (int i = 0; i < 4; i++) begin
			wr_reg(NDEA_REG_CTRL, sel_v[i]);
			repeat (3) @(posedge clk);
			#1 `CHK("target", sel_t[i], target)
			chk_rd("ctrl sel", NDEA_REG_CTRL, sel_v[i] & 8'hFE);
			chk_rd("value sel", NDEA_REG_VALUE, NDEA_ZERO);
		end
		$display("test selects done");
		start(8'h10, 8'h77);
		repeat (3) @(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		chk_rd("ctrl reset", NDEA_REG_CTRL, 8'h08);
		`CHK("busy reset", 1'b0, busy)
		$display("test reset mid write done");
		complete_run();
	end
endmodule // ndea_top_tb
